//--- hw/clk_agc_pkg.sv
// constants for the clock source and left attack time register slice
// assumes an 8-bit register port with a 7-bit register address
`default_nettype none
package clk_agc_pkg;
  // ==========================================================
  // register offsets
  localparam logic [6:0] ADDR_RESERVED_SLOT_A   = 7'h64;
  localparam logic [6:0] ADDR_CORE_CLOCK_SRC    = 7'h65;
  localparam logic [6:0] ADDR_CLOCK_GEN_CTRL    = 7'h66;
  localparam logic [6:0] ADDR_LEFT_ATTACK_TIME  = 7'h67;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_RESERVED_SLOT_A    = 8'h00;
  localparam logic [7:0] RST_CORE_CLOCK_SRC     = 8'h00;
  localparam logic [7:0] RST_CLOCK_GEN_CTRL     = 8'h02;
  localparam logic [7:0] RST_LEFT_ATTACK_TIME   = 8'h00;
  // ==========================================================
  // field positions
  localparam int         POS_CORE_SEL           = 0;
  localparam int         POS_DIV_SEL_LO         = 6;
  localparam int         POS_PLL_SEL_LO         = 4;
  localparam int         POS_PLL_N_LO           = 0;
  localparam int         POS_ATK_SRC            = 7;
  localparam int         POS_ATK_BASE_LO        = 5;
  localparam int         POS_ATK_MULT_LO        = 2;
  // writable bit masks
  localparam logic [7:0] MASK_CORE_CLOCK_SRC    = 8'h01;
  localparam logic [7:0] MASK_CLOCK_GEN_CTRL    = 8'hFF;
  localparam logic [7:0] MASK_LEFT_ATTACK_TIME  = 8'hFC;
  // ==========================================================
  // clock source codes
  localparam logic [1:0] SRC_MASTER_CLOCK       = 2'h0;
  localparam logic [1:0] SRC_BIT_CLOCK          = 2'h2;
  // pll divider codes with special meaning
  localparam logic [3:0] N_CODE_16              = 4'h0;
  localparam logic [3:0] N_CODE_17              = 4'h1;
  localparam logic [4:0] N_VALUE_16             = 5'h10;
  localparam logic [4:0] N_VALUE_17             = 5'h11;
  // baseline attack times in milliseconds
  localparam logic [3:0] ATK_MS_00              = 4'h7;
  localparam logic [3:0] ATK_MS_01              = 4'h8;
  localparam logic [3:0] ATK_MS_10              = 4'hA;
  localparam logic [3:0] ATK_MS_11              = 4'hB;
endpackage : clk_agc_pkg
`default_nettype wire

//--- hw/cfg_reg8.sv
// one 8-bit configuration register with writable mask and reset value
// assumes write strobe in the i_clk_sys domain
`default_nettype none
module cfg_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hFF
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  input  wire logic       i_we,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_value
);
  // ==========================================================
  // storage; bits outside the mask stay at their reset value
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_value <= RESET_VAL;
    end else if (i_we) begin
      o_value <= (i_wdata & WR_MASK) | (RESET_VAL & ~WR_MASK);
    end
  end
endmodule : cfg_reg8
`default_nettype wire

//--- hw/codec_clock_agc_attack_regs.sv
// clock source selection and left attack time register slice
// assumes a host register port with address, write strobe and data
`default_nettype none
module codec_clock_agc_attack_regs
  import clk_agc_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  input  wire logic [6:0] i_reg_addr,
  input  wire logic       i_reg_we,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  output logic            o_core_clock_input_sel,
  output logic      [1:0] o_divider_path_input_sel,
  output logic      [1:0] o_pll_reference_input_sel,
  output logic      [4:0] o_pll_n_value,
  output logic            o_attack_from_local,
  output logic      [3:0] o_attack_base_ms,
  output logic      [7:0] o_attack_mult,
  output logic     [10:0] o_attack_time_ms
);
  import clk_agc_pkg::*;

  logic [7:0] core_src_q;
  logic [7:0] clk_gen_q;
  logic [7:0] atk_q;
  logic [7:0] rdata_d;
  logic [3:0] base_d;
  logic [4:0] n_d;
  logic [7:0] mult_d;
  logic       rst_prev_q;

  // ==========================================================
  // registers; masked bits keep reset value
  cfg_reg8 #(.RESET_VAL(RST_CORE_CLOCK_SRC), .WR_MASK(MASK_CORE_CLOCK_SRC)) u_core (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_we      (i_reg_we && i_reg_addr == ADDR_CORE_CLOCK_SRC),
    .i_wdata   (i_reg_wdata),
    .o_value   (core_src_q)
  );
  cfg_reg8 #(.RESET_VAL(RST_CLOCK_GEN_CTRL), .WR_MASK(MASK_CLOCK_GEN_CTRL)) u_gen (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_we      (i_reg_we && i_reg_addr == ADDR_CLOCK_GEN_CTRL),
    .i_wdata   (i_reg_wdata),
    .o_value   (clk_gen_q)
  );
  cfg_reg8 #(.RESET_VAL(RST_LEFT_ATTACK_TIME), .WR_MASK(MASK_LEFT_ATTACK_TIME)) u_atk (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_we      (i_reg_we && i_reg_addr == ADDR_LEFT_ATTACK_TIME),
    .i_wdata   (i_reg_wdata),
    .o_value   (atk_q)
  );

  // ==========================================================
  // read mux; reserved slot and unmapped addresses read zero
  always_comb begin
    unique case (i_reg_addr)
      ADDR_RESERVED_SLOT_A:  rdata_d = RST_RESERVED_SLOT_A;
      ADDR_CORE_CLOCK_SRC:   rdata_d = core_src_q;
      ADDR_CLOCK_GEN_CTRL:   rdata_d = clk_gen_q;
      ADDR_LEFT_ATTACK_TIME: rdata_d = atk_q;
      default:               rdata_d = 8'h00;
    endcase
  end

  // read data registered, valid one cycle after address
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= rdata_d;
    end
  end

  // ==========================================================
  // decode divider code, baseline time and multiplier
  always_comb begin
    unique case (clk_gen_q[POS_PLL_N_LO +: 4])
      N_CODE_16: n_d = N_VALUE_16;
      N_CODE_17: n_d = N_VALUE_17;
      default:   n_d = {1'b0, clk_gen_q[POS_PLL_N_LO +: 4]};
    endcase
    unique case (atk_q[POS_ATK_BASE_LO +: 2])
      2'h0:    base_d = ATK_MS_00;
      2'h1:    base_d = ATK_MS_01;
      2'h2:    base_d = ATK_MS_10;
      default: base_d = ATK_MS_11;
    endcase
    mult_d = 8'h01 << atk_q[POS_ATK_MULT_LO +: 3];
  end

  // ==========================================================
  // control outputs from flip-flops
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_core_clock_input_sel    <= 1'b0;
      o_divider_path_input_sel  <= SRC_MASTER_CLOCK;
      o_pll_reference_input_sel <= SRC_MASTER_CLOCK;
      o_pll_n_value             <= 5'h02;
      o_attack_from_local       <= 1'b0;
      o_attack_base_ms          <= ATK_MS_00;
      o_attack_mult             <= 8'h01;
      o_attack_time_ms          <= 11'h007;
    end else begin
      o_core_clock_input_sel    <= core_src_q[POS_CORE_SEL];
      o_divider_path_input_sel  <= clk_gen_q[POS_DIV_SEL_LO +: 2];
      o_pll_reference_input_sel <= clk_gen_q[POS_PLL_SEL_LO +: 2];
      o_pll_n_value             <= n_d;
      o_attack_from_local       <= atk_q[POS_ATK_SRC];
      o_attack_base_ms          <= base_d;
      o_attack_mult             <= mult_d;
      o_attack_time_ms          <= 11'({7'h00, base_d} << atk_q[POS_ATK_MULT_LO +: 3]);
    end
  end

  // ==========================================================
  // checks
  sequence s_wr_gen;
    i_reg_we && i_reg_addr == ADDR_CLOCK_GEN_CTRL;
  endsequence
  sequence s_wr_atk;
    i_reg_we && i_reg_addr == ADDR_LEFT_ATTACK_TIME;
  endsequence

  a_reserved_reads_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_reg_addr == ADDR_RESERVED_SLOT_A |=> o_reg_rdata == 8'h00)
    else $error("reserved slot read nonzero");
  a_core_sel_follows: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_reg_we && i_reg_addr == ADDR_CORE_CLOCK_SRC |-> ##2 o_core_clock_input_sel == $past(i_reg_wdata[0], 2))
    else $error("core select not updated");
  a_core_upper_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_reg_addr == ADDR_CORE_CLOCK_SRC |=> o_reg_rdata[7:1] == 7'h00)
    else $error("core register upper bits nonzero");
  a_div_sel_write: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_wr_gen |-> ##2 o_divider_path_input_sel == $past(i_reg_wdata[7:6], 2))
    else $error("divider input select wrong");
  a_pll_ref_write: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_wr_gen |-> ##2 o_pll_reference_input_sel == $past(i_reg_wdata[5:4], 2))
    else $error("pll reference select wrong");
  a_pll_n_range: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_wr_gen |-> ##2 o_pll_n_value == (($past(i_reg_wdata[3:0], 2) < 4'h2) ?
      {4'h8, $past(i_reg_wdata[0], 2)} : {1'b0, $past(i_reg_wdata[3:0], 2)}))
    else $error("pll n value wrong");
  a_attack_src_write: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_wr_atk |-> ##2 o_attack_from_local == $past(i_reg_wdata[7], 2))
    else $error("attack source wrong");
  a_attack_low_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_wr_atk ##1 i_reg_addr == ADDR_LEFT_ATTACK_TIME |=> o_reg_rdata[1:0] == 2'h0)
    else $error("attack low bits not zero");
  a_attack_mult_pow: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_wr_atk |-> ##2 o_attack_mult == (8'h01 << $past(i_reg_wdata[4:2], 2)))
    else $error("multiplier wrong");
  a_attack_product: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ##1 o_attack_time_ms == {7'h00, o_attack_base_ms} * {3'h0, o_attack_mult})
    else $error("attack time product wrong");

  // ==========================================================
  // reset values, seen one edge after reset was sampled
  // remembers the last reset sample; needs no reset of its own
  always_ff @(posedge i_clk_sys) begin
    rst_prev_q <= i_sys_rst;
  end
  a_reset_defaults: assert property (@(posedge i_clk_sys)
    rst_prev_q |-> o_reg_rdata == 8'h00 && o_core_clock_input_sel == 1'b0 &&
      o_divider_path_input_sel == SRC_MASTER_CLOCK && o_pll_reference_input_sel == SRC_MASTER_CLOCK &&
      o_pll_n_value == 5'h02 && o_attack_from_local == 1'b0 && o_attack_base_ms == ATK_MS_00 &&
      o_attack_mult == 8'h01 && o_attack_time_ms == 11'h007)
    else $error("outputs not at reset values");

  // ==========================================================
  // read back of a written register, address held after the write
  sequence s_rd_gen_after_wr;
    s_wr_gen ##1 i_reg_addr == ADDR_CLOCK_GEN_CTRL;
  endsequence
  sequence s_rd_atk_after_wr;
    s_wr_atk ##1 i_reg_addr == ADDR_LEFT_ATTACK_TIME;
  endsequence

  a_gen_readback: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_rd_gen_after_wr |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("clock generation readback wrong");
  a_atk_readback: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_rd_atk_after_wr |=> o_reg_rdata[7:2] == $past(i_reg_wdata[7:2], 2))
    else $error("attack register readback wrong");
  a_unmapped_reads_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !(i_reg_addr inside {[ADDR_RESERVED_SLOT_A:ADDR_LEFT_ATTACK_TIME]}) |=> o_reg_rdata == 8'h00)
    else $error("unmapped address read nonzero");

  // ==========================================================
  // baseline decode and effective time after a write
  a_attack_base_map: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_wr_atk |-> ##2 o_attack_base_ms == (($past(i_reg_wdata[6:5], 2) == 2'h0) ? ATK_MS_00 :
      ($past(i_reg_wdata[6:5], 2) == 2'h1) ? ATK_MS_01 : ($past(i_reg_wdata[6:5], 2) == 2'h2) ? ATK_MS_10 : ATK_MS_11))
    else $error("baseline attack time wrong");
  a_attack_time_write: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_wr_atk |-> ##2 o_attack_time_ms == ({7'h00, o_attack_base_ms} << $past(i_reg_wdata[4:2], 2)))
    else $error("effective attack time wrong");

  // ==========================================================
  // decoded outputs stand until a write reaches their register
  a_gen_outputs_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !(i_reg_we && i_reg_addr == ADDR_CLOCK_GEN_CTRL) |-> ##2
      $stable({o_divider_path_input_sel, o_pll_reference_input_sel, o_pll_n_value}))
    else $error("clock generation outputs moved without a write");
  a_atk_outputs_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !(i_reg_we && i_reg_addr == ADDR_LEFT_ATTACK_TIME) |-> ##2
      $stable({o_attack_from_local, o_attack_base_ms, o_attack_mult, o_attack_time_ms}))
    else $error("attack outputs moved without a write");
endmodule : codec_clock_agc_attack_regs
`default_nettype wire

//--- sim/codec_clock_agc_attack_regs_tb.sv
// self-checking bench for the clock source and left attack time register slice
// assumes a single 20 MHz clock with synchronous active-high reset and no other parties
`default_nettype none
module codec_clock_agc_attack_regs_tb
  import clk_agc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // stimulus and observed signals
  logic        i_clk_sys   = 1'b0;
  logic        i_sys_rst   = 1'b1;
  logic [6:0]  i_reg_addr  = 7'h00;
  logic        i_reg_we    = 1'b0;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic [7:0]  o_reg_rdata;
  logic        o_core_clock_input_sel;
  logic [1:0]  o_divider_path_input_sel;
  logic [1:0]  o_pll_reference_input_sel;
  logic [4:0]  o_pll_n_value;
  logic        o_attack_from_local;
  logic [3:0]  o_attack_base_ms;
  logic [7:0]  o_attack_mult;
  logic [10:0] o_attack_time_ms;
  int          n_errors  = 0;
  int          cmp_count = 0;
  int          cycles    = 0;
  logic [3:0]  base_ms [4] = '{4'h7, 4'h8, 4'hA, 4'hB}; // baseline attack per code
  // clock, half period 25 ns
  always #25 i_clk_sys = ~i_clk_sys;
  codec_clock_agc_attack_regs uut (
    .i_clk_sys                 (i_clk_sys),
    .i_sys_rst                 (i_sys_rst),
    .i_reg_addr                (i_reg_addr),
    .i_reg_we                  (i_reg_we),
    .i_reg_wdata               (i_reg_wdata),
    .o_reg_rdata               (o_reg_rdata),
    .o_core_clock_input_sel    (o_core_clock_input_sel),
    .o_divider_path_input_sel  (o_divider_path_input_sel),
    .o_pll_reference_input_sel (o_pll_reference_input_sel),
    .o_pll_n_value             (o_pll_n_value),
    .o_attack_from_local       (o_attack_from_local),
    .o_attack_base_ms          (o_attack_base_ms),
    .o_attack_mult             (o_attack_mult),
    .o_attack_time_ms          (o_attack_time_ms)
  );
  // ==========================================================
  // access and compare tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_addr  <= a;
    i_reg_we    <= 1'b1;
    i_reg_wdata <= d;
    @(posedge i_clk_sys);
    i_reg_we    <= 1'b0;
  endtask : wr
  // lets the register and output flops land
  task automatic settle();
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask : settle
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    settle();
    check(o_reg_rdata, exp);
  endtask : rd
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // hang guard, the sequence needs well under 2000 cycles
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] d;
    repeat (16) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    rd(7'h64, 8'h00);
    rd(7'h65, 8'h00);
    rd(7'h66, 8'h02);
    rd(7'h67, 8'h00);
    rd(7'h10, 8'h00);
    check(o_pll_n_value, 16'h0002);
    check({o_core_clock_input_sel, o_divider_path_input_sel, o_pll_reference_input_sel}, 16'h0000);
    check({o_attack_from_local, o_attack_base_ms, o_attack_mult}, 16'h0701);
    check(o_attack_time_ms, 16'h0007);
    wr(7'h10, 8'hFF);
    rd(7'h10, 8'h00);
    rd(7'h64, 8'h00);
    wr(7'h65, 8'h01);
    rd(7'h65, 8'h01);
    check(o_core_clock_input_sel, 16'h0001);
    wr(7'h65, 8'h00);
    settle();
    check(o_core_clock_input_sel, 16'h0000);
    // every divider code, each source select stepping through both legal source codes
    for (int i = 0; i < 16; i++) begin
      d = {i[0], 1'b0, i[1], 1'b0, i[3:0]};
      wr(7'h66, d);
      settle();
      check(o_reg_rdata, d);
      check(o_divider_path_input_sel, {i[0], 1'b0});
      check(o_pll_reference_input_sel, {i[1], 1'b0});
      check(o_pll_n_value, (i == 0) ? 16'h0010 : (i == 1) ? 16'h0011 : 16'(i));
    end
    // every source, baseline and multiplier combination
    for (int j = 0; j < 64; j++) begin
      d = {j[5:0], 2'b00};
      wr(7'h67, d);
      settle();
      check(o_reg_rdata, d);
      check(o_attack_from_local, j[5]);
      check(o_attack_base_ms, base_ms[j[4:3]]);
      check(o_attack_mult, 16'h0001 << j[2:0]);
      check(o_attack_time_ms, 16'(base_ms[j[4:3]]) * (16'h0001 << j[2:0]));
    end
    // back to back writes to two registers
    @(posedge i_clk_sys);
    i_reg_addr  <= 7'h66;
    i_reg_wdata <= 8'h83;
    i_reg_we    <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_addr  <= 7'h67;
    i_reg_wdata <= 8'hFC;
    @(posedge i_clk_sys);
    i_reg_we    <= 1'b0;
    rd(7'h66, 8'h83);
    rd(7'h67, 8'hFC);
    check(o_pll_n_value, 16'h0003);
    check(o_attack_time_ms, 16'h0580);
    // second reset in mid-run restores defaults
    @(posedge i_clk_sys);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    rd(7'h66, 8'h02);
    rd(7'h67, 8'h00);
    check(o_attack_time_ms, 16'h0007);
    give_verdict();
  end
endmodule : codec_clock_agc_attack_regs_tb
`default_nettype wire
